// File: design/giw_pkg.sv
// Package: register map, field positions and reset values of the block
`default_nettype none
package giw_pkg;
  // ****************************************
  // Register bus geometry
  // ****************************************
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_GROUP = 3'h1;
  localparam logic [2:0] OFS_SRC_FLAG = 3'h2;
  localparam logic [2:0] OFS_SRC_EN = 3'h3;
  localparam logic [2:0] OFS_STATUS = 3'h4;

  // ****************************************
  // Sizes of the source and group sets
  // ****************************************
  localparam int NUM_TM = 2;
  localparam int NUM_GRP = 3;
  localparam int NUM_SRC = 6;
  localparam int MEM_PER_GRP = 2;

  // ****************************************
  // Source positions in the flag and enable registers
  // ****************************************
  localparam int SRC_TM0_P = 0;
  localparam int SRC_TM0_A = 1;
  localparam int SRC_TM1_P = 2;
  localparam int SRC_TM1_A = 3;
  localparam int SRC_LVD = 4;
  localparam int SRC_EEPROM = 5;

  // ****************************************
  // Field positions in control, group and status registers
  // ****************************************
  localparam int CTRL_GIE_BIT = 0;
  localparam int GRP_EN_LSB = 0;
  localparam int GRP_FLAG_LSB = 4;
  localparam int STAT_PEND_BIT = 0;
  localparam int STAT_STKF_BIT = 1;
  localparam int STAT_SLEEP_BIT = 2;
  localparam int STAT_IRQ_BIT = 3;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic RST_GIE = 1'b0;
  localparam logic RST_FLAG = 1'b0;
  localparam logic [5:0] RST_SRC_EN = 6'h00;
  localparam logic [2:0] RST_GRP_EN = 3'h0;
  localparam logic [1:0] RST_VEC = 2'h0;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // Power state of the core
  typedef enum logic [1:0] {
    GIW_RUN = 2'b01,
    GIW_SLEEP = 2'b10
  } giw_pwr_t;
endpackage
`default_nettype wire

// File: design/giw_grp_if.sv
// Interface: wiring between the controller and one interrupt group
`default_nettype none
interface giw_grp_if;
  logic [1:0] mem_rise;
  logic [1:0] mem_act;
  logic en;
  logic sw_wr;
  logic sw_val;
  logic svc_clr;
  logic flag;
  logic rise;
  logic req;

  modport grp (
    input mem_rise,
    input mem_act,
    input en,
    input sw_wr,
    input sw_val,
    input svc_clr,
    output flag,
    output rise,
    output req
  );
  modport ctl (
    output mem_rise,
    output mem_act,
    output en,
    output sw_wr,
    output sw_val,
    output svc_clr,
    input flag,
    input rise,
    input req
  );
endinterface
`default_nettype wire

// File: design/giw_sticky_flag.sv
// Module: one sticky source request flag with software access
`default_nettype none
module giw_sticky_flag (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic set_evt,
  input wire logic sw_wr,
  input wire logic sw_val,
  output logic flag,
  output logic rise
);
  logic flag_reg;
  logic flag_next;
  logic rise_reg;
  logic rise_next;

  // Event beats a software clear in the same cycle
  always_comb begin
    flag_next = flag_reg;
    if (sw_wr) begin
      flag_next = sw_val;
    end
    if (set_evt) begin
      flag_next = 1'b1;
    end
    rise_next = flag_next & ~flag_reg;
  end

  // No hardware clear: only software drops it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_reg <= giw_pkg::RST_FLAG;
      rise_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      rise_reg <= rise_next;
    end
  end

  assign flag = flag_reg;
  assign rise = rise_reg;
endmodule
`default_nettype wire

// File: design/giw_group.sv
// Module: one multi-function group flag and its request term
`default_nettype none
module giw_group (
  input wire logic core_clk,
  input wire logic rst,
  giw_grp_if.grp gi
);
  logic flag_reg;
  logic flag_next;
  logic rise_reg;
  logic rise_next;

  // Member rise sets, service or software clears; set wins
  always_comb begin
    flag_next = flag_reg;
    if (gi.svc_clr) begin
      flag_next = 1'b0;
    end
    if (gi.sw_wr) begin
      flag_next = gi.sw_val;
    end
    if (|gi.mem_rise) begin
      flag_next = 1'b1;
    end
    rise_next = flag_next & ~flag_reg;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_reg <= giw_pkg::RST_FLAG;
      rise_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      rise_reg <= rise_next;
    end
  end

  // Group asks only with its enable and an enabled member
  assign gi.req = flag_reg & gi.en & (|gi.mem_act);
  assign gi.flag = flag_reg;
  assign gi.rise = rise_reg;
endmodule
`default_nettype wire

// File: design/giw_irq_ctrl.sv
// Top: grouped interrupt request and wake-up controller
//
// Behaviour
// - EEPROM erase or write end sets the EEPROM completion flag.
// - EEPROM call needs global, source and group enables, stack not full.
// - EEPROM service clears global enable and group flag, not source flag.
// - Each timer module has two flags and two enables, P and A.
// - Timer comparator P or A match sets that timer flag.
// - Timer call needs global, timer and group enables, stack not full.
// - Timer service clears global enable and group flag; software clears rest.
// - Any flag rising wakes from sleep, enables ignored.
// - A set flag stays set while disabled until serviced or cleared.
// - Service pushes only the program counter, nothing else.
// - Interrupt return sets global enable; plain return leaves it clear.
// - Any member flag rising sets its group flag.
// - Three groups: two timer groups and low-voltage with EEPROM.
`default_nettype none
module giw_irq_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Event sources
  input wire logic eeprom_done_evt,
  input wire logic lvd_evt,
  input wire logic [1:0] tm_match_p,
  input wire logic [1:0] tm_match_a,
  // Processor core side
  input wire logic stack_full,
  input wire logic irq_ack,
  input wire logic isr_exit_enabling,
  input wire logic plain_sub_exit,
  input wire logic sleep_enter,
  output logic irq_req,
  output logic [1:0] irq_vec,
  output logic pc_push,
  output logic wake,
  output logic asleep
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [5:0] src_set;
  logic [5:0] src_flag;
  logic [5:0] src_rise;
  logic [5:0] src_en_reg;
  logic [5:0] src_en_next;
  logic [2:0] grp_en_reg;
  logic [2:0] grp_en_next;
  logic gie_reg;
  logic gie_next;
  logic irq_req_reg;
  logic irq_req_next;
  logic [1:0] vec_reg;
  logic [1:0] vec_next;
  logic push_reg;
  logic push_next;
  logic wake_reg;
  logic wake_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  giw_pkg::giw_pwr_t pwr_reg;
  giw_pkg::giw_pwr_t pwr_next;
  logic wr_ctrl;
  logic wr_group;
  logic wr_flag;
  logic wr_en;
  logic ack_ok;
  logic [2:0] grp_req;
  logic [2:0] grp_flag;
  logic [2:0] grp_rise;
  logic any_rise;
  logic call_ok;
  logic [1:0] sel_vec;
  logic [7:0] status_word;

  // ****************************************
  // Write decode
  // ****************************************
  assign wr_ctrl = reg_wr & (reg_addr == giw_pkg::OFS_CTRL);
  assign wr_group = reg_wr & (reg_addr == giw_pkg::OFS_GROUP);
  assign wr_flag = reg_wr & (reg_addr == giw_pkg::OFS_SRC_FLAG);
  assign wr_en = reg_wr & (reg_addr == giw_pkg::OFS_SRC_EN);

  // Acknowledge counts only against a standing request
  assign ack_ok = irq_ack & irq_req_reg;

  // ****************************************
  // Source request flags
  // ****************************************
  // Two flags per timer module, one per comparator
  assign src_set[giw_pkg::SRC_TM0_P] = tm_match_p[0];
  assign src_set[giw_pkg::SRC_TM0_A] = tm_match_a[0];
  assign src_set[giw_pkg::SRC_TM1_P] = tm_match_p[1];
  assign src_set[giw_pkg::SRC_TM1_A] = tm_match_a[1];
  assign src_set[giw_pkg::SRC_LVD] = lvd_evt;
  assign src_set[giw_pkg::SRC_EEPROM] = eeprom_done_evt;

  // Service never touches these; software owns the clear
  genvar s;
  generate
    for (s = 0; s < giw_pkg::NUM_SRC; s++) begin : g_src
      giw_sticky_flag u_flag (
        .core_clk(core_clk),
        .rst(rst),
        .set_evt(src_set[s]),
        .sw_wr(wr_flag),
        .sw_val(reg_wdata[s]),
        .flag(src_flag[s]),
        .rise(src_rise[s])
      );
    end
  endgenerate

  // ****************************************
  // Multi-function groups
  // ****************************************
  // Group g holds sources 2g and 2g+1
  giw_grp_if grp_bus [giw_pkg::NUM_GRP] ();

  genvar g;
  generate
    for (g = 0; g < giw_pkg::NUM_GRP; g++) begin : g_grp
      assign grp_bus[g].mem_rise = src_rise[2*g+1 -: 2];
      assign grp_bus[g].mem_act = src_flag[2*g+1 -: 2] &
        src_en_reg[2*g+1 -: 2];
      assign grp_bus[g].en = grp_en_reg[g];
      assign grp_bus[g].sw_wr = wr_group;
      assign grp_bus[g].sw_val = reg_wdata[giw_pkg::GRP_FLAG_LSB + g];
      // Service clears the serviced group's flag only
      assign grp_bus[g].svc_clr = ack_ok & (vec_reg == 2'(g));
      assign grp_req[g] = grp_bus[g].req;
      assign grp_flag[g] = grp_bus[g].flag;
      assign grp_rise[g] = grp_bus[g].rise;
      giw_group u_grp (
        .core_clk(core_clk),
        .rst(rst),
        .gi(grp_bus[g])
      );
    end
  endgenerate

  // ****************************************
  // Request arbitration
  // ****************************************
  // Fixed priority, group 0 highest; full stack holds it back
  always_comb begin
    sel_vec = 2'h0;
    if (grp_req[0]) begin
      sel_vec = 2'h0;
    end else if (grp_req[1]) begin
      sel_vec = 2'h1;
    end else if (grp_req[2]) begin
      sel_vec = 2'h2;
    end
  end
  assign call_ok = gie_reg & (|grp_req) & ~stack_full;

  // ****************************************
  // Enables and global enable
  // ****************************************
  // Service beats a same-cycle software set of the global enable
  always_comb begin
    gie_next = gie_reg;
    src_en_next = src_en_reg;
    grp_en_next = grp_en_reg;
    if (wr_ctrl) begin
      gie_next = reg_wdata[giw_pkg::CTRL_GIE_BIT];
    end
    if (isr_exit_enabling) begin
      gie_next = 1'b1;
    end
    if (ack_ok) begin
      gie_next = 1'b0;
    end
    if (wr_en) begin
      src_en_next = reg_wdata[giw_pkg::NUM_SRC-1:0];
    end
    if (wr_group) begin
      grp_en_next = reg_wdata[giw_pkg::GRP_EN_LSB +: giw_pkg::NUM_GRP];
    end
  end
  // A plain return is not decoded: global enable simply stays put

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gie_reg <= giw_pkg::RST_GIE;
      src_en_reg <= giw_pkg::RST_SRC_EN;
      grp_en_reg <= giw_pkg::RST_GRP_EN;
    end else begin
      gie_reg <= gie_next;
      src_en_reg <= src_en_next;
      grp_en_reg <= grp_en_next;
    end
  end

  // ****************************************
  // Vector call handshake
  // ****************************************
  // Request drops right after ack; the stale cycle is masked here
  always_comb begin
    irq_req_next = call_ok & ~ack_ok;
    vec_next = vec_reg;
    if (call_ok & ~irq_req_reg) begin
      vec_next = sel_vec;
    end
    // Core pushes the program counter only
    push_next = ack_ok;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_req_reg <= 1'b0;
      vec_reg <= giw_pkg::RST_VEC;
      push_reg <= 1'b0;
    end else begin
      irq_req_reg <= irq_req_next;
      vec_reg <= vec_next;
      push_reg <= push_next;
    end
  end

  // ****************************************
  // Sleep and wake-up
  // ****************************************
  // Any flag edge wakes, enables ignored; a flag already high cannot
  // rise again, which is how software masks a wake source
  assign any_rise = (|src_rise) | (|grp_rise);

  always_comb begin
    pwr_next = pwr_reg;
    wake_next = 1'b0;
    unique case (pwr_reg)
      giw_pkg::GIW_RUN: begin
        if (sleep_enter) begin
          pwr_next = giw_pkg::GIW_SLEEP;
        end
      end
      giw_pkg::GIW_SLEEP: begin
        if (any_rise) begin
          pwr_next = giw_pkg::GIW_RUN;
          wake_next = 1'b1;
        end
      end
      default: begin
        pwr_next = giw_pkg::GIW_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pwr_reg <= giw_pkg::GIW_RUN;
      wake_reg <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      wake_reg <= wake_next;
    end
  end

  // ****************************************
  // Register read path
  // ****************************************
  always_comb begin
    status_word = 8'h00;
    status_word[giw_pkg::STAT_PEND_BIT] = |grp_req;
    status_word[giw_pkg::STAT_STKF_BIT] = stack_full;
    status_word[giw_pkg::STAT_SLEEP_BIT] = (pwr_reg == giw_pkg::GIW_SLEEP);
    status_word[giw_pkg::STAT_IRQ_BIT] = irq_req_reg;
  end

  // Data valid only in the cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_next = giw_pkg::RST_RDATA;
    if (reg_rd) begin
      unique case (reg_addr)
        giw_pkg::OFS_CTRL: begin
          rdata_next[giw_pkg::CTRL_GIE_BIT] = gie_reg;
        end
        giw_pkg::OFS_GROUP: begin
          rdata_next[giw_pkg::GRP_EN_LSB +: giw_pkg::NUM_GRP] = grp_en_reg;
          rdata_next[giw_pkg::GRP_FLAG_LSB +: giw_pkg::NUM_GRP] = grp_flag;
        end
        giw_pkg::OFS_SRC_FLAG: begin
          rdata_next[giw_pkg::NUM_SRC-1:0] = src_flag;
        end
        giw_pkg::OFS_SRC_EN: begin
          rdata_next[giw_pkg::NUM_SRC-1:0] = src_en_reg;
        end
        giw_pkg::OFS_STATUS: begin
          rdata_next = status_word;
        end
        default: begin
          rdata_next = giw_pkg::RST_RDATA;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= giw_pkg::RST_RDATA;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = rdata_reg;
  assign irq_req = irq_req_reg;
  assign irq_vec = vec_reg;
  assign pc_push = push_reg;
  assign wake = wake_reg;
  assign asleep = (pwr_reg == giw_pkg::GIW_SLEEP);
endmodule
`default_nettype wire

// File: verif/giw_irq_chk.sv
// Checker: call, stack and sleep timing at the controller ports
`default_nettype none
module giw_irq_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic stack_full,
  input wire logic irq_ack,
  input wire logic sleep_enter,
  input wire logic irq_req,
  input wire logic [1:0] irq_vec,
  input wire logic pc_push,
  input wire logic wake,
  input wire logic asleep
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********
  // Call and stack side
  // ********
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // A taken call pushes once and drops the request
  ack_push_a: assert property (
    irq_req && irq_ack |=> pc_push && !irq_req) else $error("no push");
  push_cause_a: assert property (
    pc_push |-> $past(irq_ack) && $past(irq_req) && !$past(pc_push))
    else $error("push without ack");
  // Global enable is gone after service, so no instant re-call
  call_quiet_a: assert property (
    pc_push |-> !irq_req [*3]) else $error("request after call");
  full_hold_a: assert property (
    stack_full |=> !irq_req) else $error("request with full stack");
  req_room_a: assert property (
    $rose(irq_req) |-> !$past(stack_full)) else $error("call while full");
  vec_hold_a: assert property (
    irq_req |-> irq_vec != 2'h3 ##1 (!irq_req || $stable(irq_vec)))
    else $error("bad vector");
  // ********
  // Sleep side
  // ********
  sleep_take_a: assert property (
    sleep_enter |=> asleep) else $error("sleep not entered");
  wake_cause_a: assert property (
    wake |-> !asleep && $past(asleep) ##1 !wake) else $error("bad wake");
  wake_only_a: assert property (
    $fell(asleep) |-> wake) else $error("left sleep without wake");
endmodule
bind giw_irq_ctrl giw_irq_chk giw_irq_chk_inst (.core_clk, .rst, .stack_full,
  .irq_ack, .sleep_enter, .irq_req, .irq_vec, .pc_push, .wake, .asleep);
`default_nettype wire

// File: verif/giw_core_model.sv
// Model: processor core that takes calls, stacks the PC and returns
`default_nettype none
module giw_core_model #(
  parameter int DEPTH = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic irq_req,
  input wire logic pc_push,
  input wire logic [3:0] ack_dly,
  input wire logic ret_go,
  input wire logic ret_kind,
  output logic irq_ack,
  output logic stack_full,
  output logic isr_exit_enabling,
  output logic plain_sub_exit
);
  timeunit 1ns;
  timeprecision 1ps;
  int depth_reg;
  int wait_reg;
  // Full once DEPTH return addresses are held
  assign stack_full = depth_reg >= DEPTH;
  // Takes a call after ack_dly cycles; 4'hf stalls it forever
  always_ff @(posedge core_clk) begin
    if (rst || !irq_req || irq_ack || ack_dly == 4'hf) begin
      irq_ack <= 1'b0;
      wait_reg <= 0;
    end else begin
      irq_ack <= wait_reg >= int'(ack_dly);
      wait_reg <= wait_reg + 1;
    end
  end
  // Only the PC is stacked; bench asks for returns only when one is held
  always_ff @(posedge core_clk) begin
    if (rst) begin
      depth_reg <= 0;
      isr_exit_enabling <= 1'b0;
      plain_sub_exit <= 1'b0;
    end else begin
      depth_reg <= depth_reg + int'(pc_push) - int'(ret_go);
      isr_exit_enabling <= ret_go && ret_kind;
      plain_sub_exit <= ret_go && !ret_kind;
    end
  end
endmodule
`default_nettype wire

// File: verif/giw_irq_ctrl_bench.sv
// Testbench: random and corner-case run of the grouped interrupt controller
`default_nettype none
module giw_irq_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] A_CTL = giw_pkg::OFS_CTRL;
  localparam logic [2:0] A_GRP = giw_pkg::OFS_GROUP;
  localparam logic [2:0] A_FLG = giw_pkg::OFS_SRC_FLAG;
  localparam logic [2:0] A_ENB = giw_pkg::OFS_SRC_EN;
  logic core_clk, rst, reg_wr, reg_rd, sleep_enter, ret_go, ret_kind;
  logic irq_req, pc_push, wake, asleep, irq_ack, stack_full;
  logic isr_exit_enabling, plain_sub_exit;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [5:0] evt;
  logic [1:0] irq_vec;
  logic [3:0] ack_dly;
  int num_errors, cmp_count;
  // Source i is evt[i]: timers P/A on even/odd, then low voltage, EEPROM
  giw_irq_ctrl giw_irq_ctrl_inst (
    .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .eeprom_done_evt(evt[5]), .lvd_evt(evt[4]),
    .tm_match_p({evt[2], evt[0]}), .tm_match_a({evt[3], evt[1]}),
    .stack_full, .irq_ack, .isr_exit_enabling, .plain_sub_exit,
    .sleep_enter, .irq_req, .irq_vec, .pc_push, .wake, .asleep);
  giw_core_model giw_core_model_inst (
    .core_clk, .rst, .irq_req, .pc_push, .ack_dly, .ret_go, .ret_kind,
    .irq_ack, .stack_full, .isr_exit_enabling, .plain_sub_exit);
  // ********
  // Helpers
  // ********
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string w, input logic [7:0] e, g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rdc(input string w, input logic [2:0] a, logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(w, e, reg_rdata);
  endtask
  task automatic fire(input int i);
    @(posedge core_clk);
    evt[i] <= 1'b1;
    @(posedge core_clk);
    evt <= 6'h00;
  endtask
  task automatic nap();
    @(posedge core_clk);
    sleep_enter <= 1'b1;
    @(posedge core_clk);
    sleep_enter <= 1'b0;
    tick(1);
  endtask
  task automatic ret(input logic kd);
    @(posedge core_clk);
    ret_go <= 1'b1;
    ret_kind <= kd;
    @(posedge core_clk);
    ret_go <= 1'b0;
  endtask
  task automatic clr();
    wr(A_CTL, 8'h00);
    wr(A_FLG, 8'h00);
    wr(A_GRP, 8'h00);
    wr(A_ENB, 8'h00);
  endtask
  // Bounded wait for a one-cycle pulse: 0 push, 1 wake
  task automatic wt(input logic sel);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      #1;
      if ((sel ? wake : pc_push) === 1'b1) break;
    end
    chk(sel ? "wake" : "pc_push", 8'h01, 8'(n < 20));
    if (n == 20) wrap_up();
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Guard against a hang anywhere
  initial begin
    repeat (50000) @(posedge core_clk);
    num_errors++;
    wrap_up();
  end
  // ********
  // Main sequence
  // ********
  initial begin
    int k, i, r;
    logic [2:0] en3;
    logic [7:0] sb, gb;
    logic kd;
    {rst, reg_wr, reg_rd, sleep_enter, ret_go, ret_kind} = 6'h20;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    evt = 6'h00;
    ack_dly = 4'hf;
    num_errors = 0;
    cmp_count = 0;
    r = $urandom(68);
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    // Every offset, mapped or not, reads zero after reset
    for (k = 0; k < 8; k++) rdc("reset value", 3'(k), 8'h00);
    $display("test reset done");
    // Each source under all or random enables, then served and returned
    for (k = 0; k < 12; k++) begin
      i = k % 6;
      sb = 8'(1 << i);
      gb = 8'(1 << (i / 2));
      en3 = k < 6 ? 3'h7 : 3'($urandom % 8);
      wr(A_ENB, sb & {8{en3[0]}});
      wr(A_GRP, gb & {8{en3[1]}});
      wr(A_CTL, 8'(en3[2]));
      if (k % 3 == 2) wr(A_FLG, sb);
      else fire(i);
      tick(5);
      chk("irq_req", 8'(en3 == 3'h7), 8'(irq_req));
      rdc("src flags", A_FLG, sb);
      rdc("group reg", A_GRP, (gb << 4) | (gb & {8{en3[1]}}));
      wr(A_ENB, sb);
      wr(A_GRP, (gb << 4) | gb);
      wr(A_CTL, 8'h01);
      tick(3);
      chk("pending", 8'h01, 8'(irq_req));
      chk("vector", 8'(i / 2), 8'(irq_vec));
      ack_dly <= 4'($urandom % 4);
      wt(1'b0);
      ack_dly <= 4'hf;
      rdc("gie served", A_CTL, 8'h00);
      rdc("group served", A_GRP, gb);
      rdc("src kept", A_FLG, sb);
      kd = 1'($urandom % 2);
      ret(kd);
      tick(3);
      rdc("gie returned", A_CTL, 8'(kd));
      clr();
    end
    $display("test sources done");
    // Full stack: a ready call waits until the core pops
    ack_dly <= 4'h0;
    wr(A_ENB, 8'h3f);
    wr(A_GRP, 8'h07);
    wr(A_CTL, 8'h01);
    fire(4);
    wt(1'b0);
    wr(A_CTL, 8'h01);
    fire(0);
    tick(6);
    chk("held call", 8'h00, 8'(irq_req));
    // Pending group and full stack both show while the call is held
    rdc("status held", giw_pkg::OFS_STATUS, 8'h03);
    ret(1'b0);
    wt(1'b0);
    rdc("groups served", A_GRP, 8'h07);
    ack_dly <= 4'hf;
    ret(1'b1);
    clr();
    $display("test stack done");
    // Sleep with every enable clear; a flag already high cannot wake
    for (k = 0; k < 6; k++) begin
      i = int'($urandom % 6);
      nap();
      chk("asleep", 8'h01, 8'(asleep));
      if (k % 2) wr(A_FLG, 8'(1 << i));
      else fire(i);
      wt(1'b1);
      nap();
      fire(i);
      tick(6);
      chk("preset masks", 8'h01, 8'(asleep));
      // Asleep, nothing enabled, so no pending group and no request
      rdc("status asleep", giw_pkg::OFS_STATUS, 8'h04);
      fire((i + 2) % 6);
      wt(1'b1);
      clr();
    end
    $display("test sleep done");
    wrap_up();
  end
endmodule
`default_nettype wire
